// >>> include/pmrc_pkg.sv
// shared constants and types of the power-mode and regulator controller
package pmrc_pkg;
	// special-function addresses on the core bus
	localparam logic [7:0] SFR_REGCTL = 8'hC9; // regulator_control, every page
	localparam logic [7:0] SFR_PWRCTL = 8'h87; // power_control
	localparam logic [7:0] SFR_OSCCTL = 8'hB2; // internal_osc_control
	// regulator_control fields
	localparam int RC_MAIN_DIS = 7; // main_regulator_disable
	localparam int RC_BUS_V = 6; // bus_voltage_status, read only
	localparam int RC_MAIN_LP = 4; // main_regulator_lowpower
	localparam int RC_STOP_CFG = 3; // stop_regulator_config
	localparam int RC_CORE_LP = 1; // core_regulator_lowpower
	localparam logic [7:0] RC_RSVD_MASK = 8'h25; // reserved bits 5, 2, 0
	// power_control and internal_osc_control fields
	localparam int PC_IDLE = 0; // idle select
	localparam int PC_STOP = 1; // stop select
	localparam int OC_SUSPEND = 5; // suspend select
	// reset values
	localparam logic [7:0] REGCTL_RESET = 8'h00;
	localparam logic [7:0] PWRCTL_RESET = 8'h00;
	localparam logic [7:0] OSCCTL_RESET = 8'h00;
	// instructions between core low-power and suspend
	localparam logic [3:0] CORE_LP_SETTLE = 4'hC;
	// controller register offsets on the lite bus
	localparam logic [3:0] AXI_CMD = 4'h0;
	localparam logic [3:0] AXI_STEP = 4'h4;
	localparam logic [3:0] AXI_STAT = 4'h8;
	// command word fields
	localparam int CMD_DATA_LSB = 8; // write data at [15:8]
	localparam int CMD_READ = 16; // 1: read, 0: write
	// status word fields
	localparam int ST_BUSY = 8;
	localparam int ST_HALT = 9;
	localparam int ST_MODE = 10; // two bits
	localparam int ST_WAKE = 12;
	localparam int ST_RESET = 13;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// power modes
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_IDLE = 2'b01,
		MODE_STOP = 2'b10,
		MODE_SUSPEND = 2'b11
	} pmrc_mode_t;
endpackage

// >>> include/pmrc_sfr_if.sv
// core special-function bus between cpu end and power controller
`timescale 1ns/1ns
interface pmrc_sfr_if;
	logic [7:0] sfr_addr; // register address
	logic [7:0] sfr_wdata; // write data
	logic sfr_wr; // write strobe, one cycle
	logic sfr_rd; // read strobe, one cycle
	logic [7:0] sfr_rdata; // read data, cycle after sfr_rd
	logic instr_done; // setting instruction completed
	logic cpu_halted; // cpu clock held off
	logic wake_irq; // wake interrupt to service, pulse
	logic cpu_restart; // restart at 0x0000, pulse
	pmrc_pkg::pmrc_mode_t mode; // present power mode
	modport dev (
		input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, instr_done,
		output sfr_rdata, cpu_halted, wake_irq, cpu_restart, mode
	);
	modport cpu (
		output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, instr_done,
		input sfr_rdata, cpu_halted, wake_irq, cpu_restart, mode
	);
endinterface

// >>> hw/pmrc_dev.sv
// power-mode sequencer and regulator control register
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module pmrc_dev
	import pmrc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	pmrc_sfr_if.dev sfr,
	input wire logic bus_voltage,
	input wire logic vbus_irq_en,
	input wire logic irq_pending,
	input wire logic watchdog_en,
	input wire logic watchdog_expire,
	input wire logic mcd_en,
	input wire logic mcd_expire,
	input wire logic reset_pin,
	input wire logic resume_signal,
	input wire logic resume_irq_en,
	output logic main_regulator_en,
	output logic main_regulator_lowpower,
	output logic core_regulator_lowpower,
	output logic core_regulator_off,
	output logic int_osc_run,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic vbus_irq,
	output logic sys_reset
);
	import pmrc_pkg::*;

	// stored state
	logic [7:0] regctl_reg; // regulator_control, bit 6 kept zero
	logic [7:0] regctl_next;
	logic [7:0] pwrctl_reg; // general flags, bits 1:0 kept zero
	logic [7:0] pwrctl_next;
	logic [7:0] oscctl_reg; // internal_osc_control, suspend bit kept zero
	logic [7:0] oscctl_next;
	pmrc_mode_t mode_reg; // present power mode
	pmrc_mode_t mode_next;
	pmrc_mode_t armed_reg; // mode waiting for instruction end
	pmrc_mode_t armed_next;
	logic vbus_prev_reg; // last bus-voltage sample
	logic [7:0] rdata_reg; // read answer
	logic wake_reg; // wake interrupt pulse
	logic restart_reg; // restart pulse
	logic halt_reg; // cpu halted level
	logic main_en_reg;
	logic main_lp_reg;
	logic core_lp_reg;
	logic core_off_reg;
	logic osc_reg;
	logic cpu_clk_reg;
	logic per_clk_reg;
	logic vbus_irq_reg;
	logic sys_reset_reg;

	// address decode, same on every page
	wire hit_regctl = sfr.sfr_addr == SFR_REGCTL;
	wire hit_pwrctl = sfr.sfr_addr == SFR_PWRCTL;
	wire hit_oscctl = sfr.sfr_addr == SFR_OSCCTL;
	wire wr_regctl = sfr.sfr_wr & hit_regctl;
	wire wr_pwrctl = sfr.sfr_wr & hit_pwrctl;
	wire wr_oscctl = sfr.sfr_wr & hit_oscctl;

	// mode requests carried by this write
	wire req_stop = wr_pwrctl & sfr.sfr_wdata[PC_STOP];
	wire req_idle = wr_pwrctl & sfr.sfr_wdata[PC_IDLE];
	wire req_susp = wr_oscctl & sfr.sfr_wdata[OC_SUSPEND];

	// regulator shut in stop leaves only the reset pin
	wire stop_off = (mode_reg == MODE_STOP) & regctl_reg[RC_STOP_CFG];
	wire wd_rst = watchdog_en & watchdog_expire;
	wire mcd_rst = mcd_en & mcd_expire;
	wire rst_any = reset_pin | (~stop_off & (wd_rst | mcd_rst));

	// request of this cycle beats an older armed one
	wire any_req = req_stop | req_idle | req_susp;
	wire [1:0] req_code = req_stop ? MODE_STOP : (req_idle ? MODE_IDLE : MODE_SUSPEND);
	wire [1:0] pend_code = any_req ? req_code : armed_reg;

	// live read value of regulator_control
	wire [7:0] regctl_view = {regctl_reg[7], bus_voltage, regctl_reg[5:0]};
	wire [7:0] pwrctl_view = {pwrctl_reg[7:2], 2'h0};
	wire [7:0] oscctl_view = oscctl_reg;
	wire [7:0] rd_mux = hit_regctl ? regctl_view :
		(hit_pwrctl ? pwrctl_view : (hit_oscctl ? oscctl_view : 8'h00));

	// register next values
	always_comb
	begin
		regctl_next = regctl_reg;
		pwrctl_next = pwrctl_reg;
		oscctl_next = oscctl_reg;
		if (rst_any)
		begin
			// normal reset sequence restores defaults
			regctl_next = REGCTL_RESET;
			pwrctl_next = PWRCTL_RESET;
			oscctl_next = OSCCTL_RESET;
		end
		else
		begin
			// bits 7,5,4,3,2,1,0 store, bit 6 only reflects the pin
			if (wr_regctl)
				regctl_next = sfr.sfr_wdata & ~(8'h01 << RC_BUS_V);
			// mode select bits never store
			if (wr_pwrctl)
				pwrctl_next = {sfr.sfr_wdata[7:2], 2'h0};
			if (wr_oscctl)
				oscctl_next = sfr.sfr_wdata & ~(8'h01 << OC_SUSPEND);
		end
	end

	// power mode sequencing
	always_comb
	begin
		mode_next = mode_reg;
		armed_next = armed_reg;
		if (rst_any)
		begin
			// any reset ends every mode
			mode_next = MODE_RUN;
			armed_next = MODE_RUN;
		end
		else
		begin
			unique case (mode_reg)
				MODE_RUN:
				begin
					// enter only once the setting instruction ends
					if (sfr.instr_done && pend_code != MODE_RUN)
					begin
						mode_next = pmrc_mode_t'(pend_code);
						armed_next = MODE_RUN;
					end
					else if (any_req)
						armed_next = pmrc_mode_t'(req_code);
				end
				MODE_IDLE:
				begin
					// enabled interrupt wakes idle
					if (irq_pending)
						mode_next = MODE_RUN;
				end
				MODE_STOP:
				begin
					// interrupts ignored, only a reset leaves
					mode_next = MODE_STOP;
				end
				MODE_SUSPEND:
				begin
					// resume signalling wakes, cpu kept running
					if (resume_signal)
						mode_next = MODE_RUN;
				end
			endcase
		end
	end

	// wake interrupt on leaving idle or suspend without reset
	wire idle_wake = (mode_reg == MODE_IDLE) & (mode_next == MODE_RUN) & ~rst_any;
	wire susp_wake = (mode_reg == MODE_SUSPEND) & (mode_next == MODE_RUN) & ~rst_any;
	wire wake_now = idle_wake | (susp_wake & resume_irq_en);

	// clock gates follow the coming mode
	wire next_osc = (mode_next == MODE_RUN) | (mode_next == MODE_IDLE);
	wire next_cpu = (mode_next == MODE_RUN) | (mode_next == MODE_SUSPEND);
	wire next_per = mode_next != MODE_STOP;
	wire next_off = (mode_next == MODE_STOP) & regctl_next[RC_STOP_CFG];

	// control state and register file
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			regctl_reg <= REGCTL_RESET;
			pwrctl_reg <= PWRCTL_RESET;
			oscctl_reg <= OSCCTL_RESET;
			mode_reg <= MODE_RUN;
			armed_reg <= MODE_RUN;
		end
		else
		begin
			regctl_reg <= regctl_next;
			pwrctl_reg <= pwrctl_next;
			oscctl_reg <= oscctl_next;
			mode_reg <= mode_next;
			armed_reg <= armed_next;
		end
	end

	// bus answers and cpu handshakes
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_reg <= 8'h00;
			wake_reg <= 1'b0;
			restart_reg <= 1'b0;
			halt_reg <= 1'b0;
			vbus_prev_reg <= 1'b0;
			vbus_irq_reg <= 1'b0;
			sys_reset_reg <= 1'b0;
		end
		else
		begin
			if (sfr.sfr_rd)
				rdata_reg <= rd_mux;
			wake_reg <= wake_now;
			restart_reg <= rst_any;
			sys_reset_reg <= rst_any;
			halt_reg <= ~next_cpu;
			vbus_prev_reg <= bus_voltage;
			// both edges, no pending flag held
			vbus_irq_reg <= vbus_irq_en & (bus_voltage ^ vbus_prev_reg);
		end
	end

	// regulator and clock controls
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			main_en_reg <= 1'b1;
			main_lp_reg <= 1'b0;
			core_lp_reg <= 1'b0;
			core_off_reg <= 1'b0;
			osc_reg <= 1'b1;
			cpu_clk_reg <= 1'b1;
			per_clk_reg <= 1'b1;
		end
		else
		begin
			main_en_reg <= ~regctl_next[RC_MAIN_DIS];
			main_lp_reg <= regctl_next[RC_MAIN_LP];
			core_lp_reg <= regctl_next[RC_CORE_LP];
			core_off_reg <= next_off;
			osc_reg <= next_osc;
			cpu_clk_reg <= next_cpu;
			per_clk_reg <= next_per;
		end
	end

	// interface drive
	assign sfr.sfr_rdata = rdata_reg;
	assign sfr.cpu_halted = halt_reg;
	assign sfr.wake_irq = wake_reg;
	assign sfr.cpu_restart = restart_reg;
	assign sfr.mode = mode_reg;
	// user-side drive
	assign main_regulator_en = main_en_reg;
	assign main_regulator_lowpower = main_lp_reg;
	assign core_regulator_lowpower = core_lp_reg;
	assign core_regulator_off = core_off_reg;
	assign int_osc_run = osc_reg;
	assign cpu_clk_en = cpu_clk_reg;
	assign periph_clk_en = per_clk_reg;
	assign vbus_irq = vbus_irq_reg;
	assign sys_reset = sys_reset_reg;
endmodule // pmrc_dev

// >>> hw/pmrc_cpu.sv
// cpu-side end: lite-bus command registers driving the core bus
`timescale 1ns/1ns
module pmrc_cpu
	import pmrc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	pmrc_sfr_if.cpu sfr
);
	import pmrc_pkg::*;

	logic aw_got_reg; // address held
	logic w_got_reg; // data held
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [7:0] s_addr_reg; // core bus address
	logic [7:0] s_wdata_reg; // core bus data
	logic s_wr_reg;
	logic s_rd_reg;
	logic step_reg; // instruction end pulse
	logic rd_wait_reg; // read answer due
	logic [7:0] last_rd_reg; // captured read data
	logic wake_seen_reg; // sticky wake
	logic rst_seen_reg; // sticky restart
	logic [3:0] settle_reg; // instructions since core low-power

	// write runs once address and data are both held
	wire do_wr = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire wr_cmd = do_wr & (aw_addr_reg == AXI_CMD);
	wire wr_step = do_wr & (aw_addr_reg == AXI_STEP);
	wire wr_stat = do_wr & (aw_addr_reg == AXI_STAT);
	wire wr_map = wr_cmd | wr_step | wr_stat;
	wire cmd_read = w_data_reg[CMD_READ];
	wire [7:0] c_addr = w_data_reg[7:0];
	wire [7:0] c_data = w_data_reg[CMD_DATA_LSB +: 8];
	wire busy = rd_wait_reg | s_rd_reg;
	wire launch = wr_cmd & ~busy;

	// reserved bits forced zero, core low-power only with main on
	wire to_reg = c_addr == SFR_REGCTL;
	wire [7:0] rc_clean = c_data & ~RC_RSVD_MASK;
	wire core_ok = ~rc_clean[RC_MAIN_DIS];
	wire [7:0] rc_safe = {rc_clean[7:2], rc_clean[RC_CORE_LP] & core_ok, 1'b0};
	// suspend held back until core regulator settled
	wire to_osc = c_addr == SFR_OSCCTL;
	wire settled = settle_reg >= CORE_LP_SETTLE;
	wire [7:0] osc_safe = c_data & ~({7'h00, ~settled} << OC_SUSPEND);
	wire [7:0] sfr_val = to_reg ? rc_safe : (to_osc ? osc_safe : c_data);
	wire lp_set = launch & ~cmd_read & to_reg & rc_safe[RC_CORE_LP];

	// status word and read decode
	wire [31:0] stat_word = {18'h00000, rst_seen_reg, wake_seen_reg, sfr.mode,
		sfr.cpu_halted, busy, last_rd_reg};
	wire ar_map = (araddr == AXI_STAT) | (araddr == AXI_CMD);
	wire ar_take = arvalid & ~rvalid_reg;

	// lite-bus write channels
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h00000000;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && !aw_got_reg)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && !w_got_reg)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= wdata;
			end
			if (do_wr)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_map && !(wr_cmd && busy)) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && bready)
				bvalid_reg <= 1'b0;
		end
	end

	// lite-bus read channel
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= (araddr == AXI_STAT) ? stat_word : 32'h00000000;
			rresp_reg <= ar_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && rready)
			rvalid_reg <= 1'b0;
	end

	// core bus strobes and captured answers
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			s_addr_reg <= 8'h00;
			s_wdata_reg <= 8'h00;
			s_wr_reg <= 1'b0;
			s_rd_reg <= 1'b0;
			step_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			last_rd_reg <= 8'h00;
			wake_seen_reg <= 1'b0;
			rst_seen_reg <= 1'b0;
			settle_reg <= CORE_LP_SETTLE;
		end
		else
		begin
			s_wr_reg <= launch & ~cmd_read;
			s_rd_reg <= launch & cmd_read;
			step_reg <= wr_step;
			rd_wait_reg <= s_rd_reg;
			if (launch)
			begin
				s_addr_reg <= c_addr;
				s_wdata_reg <= sfr_val;
			end
			if (rd_wait_reg)
				last_rd_reg <= sfr.sfr_rdata;
			// set beats clear
			wake_seen_reg <= sfr.wake_irq | (wake_seen_reg & ~(wr_stat & w_data_reg[ST_WAKE]));
			rst_seen_reg <= sfr.cpu_restart | (rst_seen_reg & ~(wr_stat & w_data_reg[ST_RESET]));
			// count instructions after core low-power set
			if (lp_set)
				settle_reg <= 4'h0;
			else if (step_reg && !settled)
				settle_reg <= settle_reg + 4'h1;
		end
	end

	assign awready = ~aw_got_reg;
	assign wready = ~w_got_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = ~rvalid_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign sfr.sfr_addr = s_addr_reg;
	assign sfr.sfr_wdata = s_wdata_reg;
	assign sfr.sfr_wr = s_wr_reg;
	assign sfr.sfr_rd = s_rd_reg;
	assign sfr.instr_done = step_reg;
endmodule // pmrc_cpu

// >>> sim/pmrc_asserts.sv
// concurrent checks on the core special-function bus
`timescale 1ns/1ns
module pmrc_asserts
	import pmrc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic instr_done,
	input wire logic cpu_halted,
	input wire logic wake_irq,
	input wire logic cpu_restart,
	input wire pmrc_pkg::pmrc_mode_t mode
);
	import pmrc_pkg::*;
	logic idle_req_reg; // idle write waiting for instruction end
	logic [7:0] reg_copy_reg; // live bits last written to regulator_control
	// follow pending idle request and written register copy
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			idle_req_reg <= 1'b0;
			reg_copy_reg <= 8'h00;
		end
		else
		begin
			if (instr_done || cpu_restart)
				idle_req_reg <= 1'b0;
			else if (sfr_wr && sfr_addr == SFR_PWRCTL)
				idle_req_reg <= (sfr_wdata == 8'h01);
			if (cpu_restart)
				reg_copy_reg <= 8'h00;
			else if (sfr_wr && sfr_addr == SFR_REGCTL)
				reg_copy_reg <= sfr_wdata & 8'h9A;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_IDLE_ENTRY: assert property
		(instr_done && idle_req_reg && mode == MODE_RUN |=> mode == MODE_IDLE)
		else $error("idle not entered at instruction end");
	AST_IDLE_HALT: assert property (mode == MODE_IDLE [*2] |-> cpu_halted)
		else $error("cpu not halted in idle");
	AST_RUN_FREE: assert property (mode == MODE_RUN [*2] |-> !cpu_halted)
		else $error("cpu halted while running");
	AST_SUSP_RUNS: assert property (mode == MODE_SUSPEND [*2] |-> !cpu_halted)
		else $error("cpu halted in suspend");
	AST_IDLE_EXIT: assert property
		(mode == MODE_IDLE ##1 mode == MODE_RUN |-> wake_irq != cpu_restart)
		else $error("idle left without wake or restart");
	AST_STOP_HOLD: assert property
		(mode == MODE_STOP |=> (mode == MODE_STOP || mode == MODE_RUN) && !wake_irq)
		else $error("stop left other than by reset");
	AST_STOP_EXIT: assert property (mode == MODE_STOP ##1 mode == MODE_RUN |-> cpu_restart)
		else $error("stop left without restart");
	AST_PWR_RD_ZERO: assert property
		(sfr_rd && sfr_addr == SFR_PWRCTL |=> sfr_rdata[1:0] == 2'b00)
		else $error("mode select bits read nonzero");
	AST_RSVD_WR: assert property
		(sfr_wr && sfr_addr == SFR_REGCTL |-> (sfr_wdata & RC_RSVD_MASK) == 8'h00)
		else $error("reserved bits written nonzero");
	AST_REG_RDBACK: assert property
		(sfr_rd && sfr_addr == SFR_REGCTL && !cpu_restart |=> (sfr_rdata & 8'h9A) == reg_copy_reg)
		else $error("regulator bits read back wrong");
	COV_IDLE: cover property (mode == MODE_RUN ##1 mode == MODE_IDLE);
	COV_STOP: cover property (mode == MODE_RUN ##1 mode == MODE_STOP);
	COV_SUSP: cover property (mode == MODE_RUN ##1 mode == MODE_SUSPEND);
endmodule // pmrc_asserts

// >>> sim/pmrc_tb_top.sv
// self-checking bench for the power-mode and regulator controller
`timescale 1ns/1ns
module power_mode_regulator_ctrl_tb_top
	import pmrc_pkg::*;
;
	import pmrc_pkg::*;
	logic clock = 1'b0; // 25 MHz system clock
	logic resetn = 1'b0; // reset, active low
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_val;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic bus_voltage = 1'b0, vbus_irq_en = 1'b1, watchdog_en = 1'b0, mcd_en = 1'b0;
	logic resume_irq_en = 1'b1;
	logic [4:0] evt = 5'h00; // wdog, mcd, pin, resume, irq pulses
	logic main_regulator_en, main_regulator_lowpower, core_regulator_lowpower, core_regulator_off;
	logic int_osc_run, cpu_clk_en, periph_clk_en, vbus_irq, sys_reset;
	logic [7:0] wtab [3] = '{8'hFF, 8'h12, 8'h08}; // written regulator values
	logic [7:0] rtab [3] = '{8'hD8, 8'h52, 8'h48}; // expected read-back, bus present
	int num_errors = 0, total_checks = 0, vbus_pulses = 0, rst_pulses = 0;
	always #20 clock = ~clock;
	// count bus-voltage interrupt and system reset pulses
	always @(posedge clock)
	begin
		if (vbus_irq === 1'b1)
			vbus_pulses++;
		if (sys_reset === 1'b1)
			rst_pulses++;
	end
	pmrc_sfr_if pmrc_sfr_if_inst ();
	pmrc_cpu pmrc_cpu_inst (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sfr(pmrc_sfr_if_inst.cpu));
	pmrc_dev pmrc_dev_inst (.clock(clock), .resetn(resetn), .sfr(pmrc_sfr_if_inst.dev),
		.bus_voltage(bus_voltage), .vbus_irq_en(vbus_irq_en), .irq_pending(evt[4]),
		.watchdog_en(watchdog_en), .watchdog_expire(evt[0]), .mcd_en(mcd_en),
		.mcd_expire(evt[1]), .reset_pin(evt[2]), .resume_signal(evt[3]),
		.resume_irq_en(resume_irq_en), .main_regulator_en(main_regulator_en),
		.main_regulator_lowpower(main_regulator_lowpower),
		.core_regulator_lowpower(core_regulator_lowpower),
		.core_regulator_off(core_regulator_off), .int_osc_run(int_osc_run),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .vbus_irq(vbus_irq),
		.sys_reset(sys_reset));
	pmrc_asserts pmrc_asserts_inst (.clock(clock), .resetn(resetn),
		.sfr_addr(pmrc_sfr_if_inst.sfr_addr), .sfr_wdata(pmrc_sfr_if_inst.sfr_wdata),
		.sfr_wr(pmrc_sfr_if_inst.sfr_wr), .sfr_rd(pmrc_sfr_if_inst.sfr_rd),
		.sfr_rdata(pmrc_sfr_if_inst.sfr_rdata), .instr_done(pmrc_sfr_if_inst.instr_done),
		.cpu_halted(pmrc_sfr_if_inst.cpu_halted), .wake_irq(pmrc_sfr_if_inst.wake_irq),
		.cpu_restart(pmrc_sfr_if_inst.cpu_restart), .mode(pmrc_sfr_if_inst.mode));
	// compare a word and count it
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// lite-bus write, each channel held until taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int n;
	begin
		n = 0;
		tb = 1'b0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb && n < 100)
		begin
			@(negedge clock);
			ta = (awready === 1'b1);
			tw = (wready === 1'b1);
			tb = (bvalid === 1'b1);
			resp = bresp;
			n++;
			@(posedge clock);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk_val({31'h0, tb}, 32'h1);
		chk_val({30'h0, resp}, {30'h0, RESP_OKAY});
	end
	endtask
	// lite-bus read into rd_val
	task automatic axi_rd(input logic [3:0] a);
		logic tr, ta;
		int n;
	begin
		n = 0;
		tr = 1'b0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr && n < 100)
		begin
			@(negedge clock);
			ta = (arready === 1'b1);
			tr = (rvalid === 1'b1);
			rd_val = rdata;
			resp = rresp;
			n++;
			@(posedge clock);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk_val({31'h0, tr}, 32'h1);
	end
	endtask
	// poll status until the command engine is free
	task automatic wait_idle;
		int n;
	begin
		n = 0;
		do
		begin
			axi_rd(AXI_STAT);
			n++;
		end
		while (rd_val[ST_BUSY] !== 1'b0 && n < 20);
		// a command engine that stays busy counts as a mismatch
		chk_val({31'h0, rd_val[ST_BUSY]}, 32'h0);
	end
	endtask
	// core-bus write or read through the command word
	task automatic sfr_put(input logic [7:0] a, input logic [7:0] d, input logic rd);
	begin
		axi_wr(AXI_CMD, {15'h0, rd, d, a});
		wait_idle();
	end
	endtask
	// instruction end, then let the mode settle
	task automatic step;
	begin
		axi_wr(AXI_STEP, 32'h0);
		repeat (4) @(posedge clock);
	end
	endtask
	// one-cycle pulse on a device event input
	task automatic fire(input int b);
	begin
		@(posedge clock);
		evt[b] <= 1'b1;
		@(posedge clock);
		evt[b] <= 1'b0;
		repeat (4) @(posedge clock);
	end
	endtask
	// status: restart, wake, mode, halt; then clear stickies
	task automatic chk_mode(input pmrc_mode_t m, input logic h, input logic [1:0] st);
	begin
		wait_idle();
		chk_val({27'h0, rd_val[13:9]}, {27'h0, st, m, h});
		axi_wr(AXI_STAT, 32'h3000);
	end
	endtask
	// verdict and end of run
	task automatic close_out;
	begin
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		sfr_put(SFR_REGCTL, 8'h00, 1'b1);
		chk_val(rd_val & 32'hFF, {24'h0, REGCTL_RESET});
		chk_val({31'h0, main_regulator_en}, 32'h1);
		bus_voltage <= 1'b1;
		repeat (4) @(posedge clock);
		chk_val(vbus_pulses, 32'h1);
		$display("test reset and bus voltage done");
		for (int i = 0; i < 3; i++)
		begin
			sfr_put(SFR_REGCTL, wtab[i], 1'b0);
			sfr_put(SFR_REGCTL, 8'h00, 1'b1);
			chk_val(rd_val & 32'hFF, {24'h0, rtab[i]});
			chk_val({29'h0, main_regulator_en, main_regulator_lowpower, core_regulator_lowpower},
				{29'h0, ~rtab[i][7], rtab[i][4], rtab[i][1]});
		end
		axi_rd(4'hC);
		chk_val({30'h0, resp}, {30'h0, RESP_SLVERR});
		$display("test regulator register done");
		sfr_put(SFR_PWRCTL, 8'h02, 1'b0);
		step();
		chk_mode(MODE_STOP, 1'b1, 2'b00);
		chk_val({29'h0, core_regulator_off, int_osc_run, periph_clk_en}, 32'h4);
		watchdog_en <= 1'b1;
		mcd_en <= 1'b1;
		fire(4);
		fire(0);
		fire(1);
		chk_mode(MODE_STOP, 1'b1, 2'b00);
		fire(2);
		chk_mode(MODE_RUN, 1'b0, 2'b10);
		sfr_put(SFR_REGCTL, 8'h00, 1'b1);
		chk_val(rd_val & 32'hFF, 32'h40);
		sfr_put(SFR_PWRCTL, 8'h02, 1'b0);
		step();
		fire(1);
		chk_mode(MODE_RUN, 1'b0, 2'b10);
		$display("test stop done");
		sfr_put(SFR_PWRCTL, 8'h01, 1'b0);
		sfr_put(SFR_PWRCTL, 8'h00, 1'b1);
		chk_val(rd_val & 32'hFF, 32'h0);
		step();
		chk_mode(MODE_IDLE, 1'b1, 2'b00);
		chk_val({29'h0, cpu_clk_en, int_osc_run, periph_clk_en}, 32'h3);
		fire(4);
		chk_mode(MODE_RUN, 1'b0, 2'b01);
		sfr_put(SFR_PWRCTL, 8'h01, 1'b0);
		step();
		fire(0);
		chk_mode(MODE_RUN, 1'b0, 2'b10);
		$display("test idle done");
		sfr_put(SFR_REGCTL, 8'h02, 1'b0);
		sfr_put(SFR_OSCCTL, 8'h20, 1'b0);
		step();
		chk_mode(MODE_RUN, 1'b0, 2'b00);
		repeat (12) step();
		sfr_put(SFR_OSCCTL, 8'h20, 1'b0);
		step();
		chk_mode(MODE_SUSPEND, 1'b0, 2'b00);
		chk_val({29'h0, cpu_clk_en, int_osc_run, periph_clk_en}, 32'h5);
		fire(3);
		chk_mode(MODE_RUN, 1'b0, 2'b01);
		bus_voltage <= 1'b0;
		repeat (4) @(posedge clock);
		chk_val(vbus_pulses, 32'h2);
		chk_val(rst_pulses, 32'h3);
		$display("test suspend done");
		close_out();
	end
	// cut a hang short
	initial
	begin
		#400000;
		num_errors++;
		close_out();
	end
endmodule // power_mode_regulator_ctrl_tb_top
